// File: hw/tch_host_ctrl.sv
// Host control register bank and second time base of the timer coprocessor
// Operation
// - Gate bit set: pin gates sysclk/8
// - Gate bit clear: synced filtered pin clocks counter
// - Prescaler codes divide by 1,2,4,8
// - Emulation: fetch from emulation RAM, bus blocked
// - Emulation bit writable once after reset
// - Stop bit gates internal clocks
// - Stopped counters hold their values
// - Stopped flag shows stop took effect
// - Enable bit per channel gates requests
// - Flags set only by microcode command
// - Request needs flag, enable, nonzero level
// - Flag cleared by read then write zero
// - Flag register alone accepts byte access
// - Four-bit function select for channels 8..15; channels 0..7 fixed at zero
// - Function codes F..6 or F..8 per set
// - Host sequence passed to function as mode
// - Service field zero means nothing pending
// - Priority 00 off, 01/10/11 low/mid/high
// - Other registers word access, unused read zero
`timescale 1ns/1ps
module tch_host_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tch_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External counter pin
  input wire logic counter2_external_pin,
  // Microengine side
  input wire logic stop_ack,
  input wire logic [15:0] time_base_one,
  input wire tch_pkg::tch_engine_t engine_status,
  output tch_pkg::tch_ctrl_t ctrl,
  output logic [15:0] time_base_two,
  output logic [tch_pkg::NUM_CH-1:0] channel_irq,
  output logic [tch_pkg::IRQ_LEVEL_W-1:0] irq_request_level,
  output logic emulation_ram_bus_block
);
  import tch_pkg::*;

  // ==========================================================================
  // Registers
  logic [1:0] prescale; // Second counter prescaler code
  logic counter2_gate_select; // Pin gates sysclk_div_eight when set
  logic emulation_enable; // Emulation mode
  logic emu_locked; // First write taken
  logic stop_req; // Software stop request
  logic stopped_flag; // Stop has taken effect
  logic [NUM_CH-1:0] channel_irq_enable_reg; // Per channel enable
  logic [NUM_CH-1:0] channel_irq_flag_reg; // Per channel flag
  logic [NUM_CH-1:0] flag_read_seen; // Flags seen set by a read
  logic [NUM_CH*4-1:0] func_sel; // Function select fields
  logic [NUM_CH*2-1:0] host_seq; // Host sequence fields
  logic [NUM_CH*2-1:0] host_svc; // Host service request fields
  logic [NUM_CH-1:0] channel_priority_reg_a; // Channels 8..15 priority
  logic [NUM_CH-1:0] channel_priority_reg_b; // Channels 0..7 priority

  // ==========================================================================
  // Bus decode
  logic access; // Access phase of a transfer
  logic wr; // Write taking effect
  logic rd; // Read taking effect
  logic word_acc; // Both lanes of the low 16-bit half enabled
  logic mapped; // Address hits a register
  logic [31:0] next_prdata; // Read mux

  assign access = psel && penable;
  assign pready = 1'b1;
  assign wr = access && pwrite && !pslverr;
  assign rd = access && !pwrite;

  // Word access means both bytes of the low half are enabled
  function automatic logic is_word(input logic [3:0] strb);
    return strb[1:0] == 2'b11;
  endfunction : is_word

  // Write data merged with lane strobes, so byte writes leave other bytes alone
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign word_acc = is_word(pstrb);

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      OFS_MODULE_CONFIG, OFS_IRQ_CONFIG, OFS_IRQ_ENABLE, OFS_FUNC_SEL_A, OFS_FUNC_SEL_B,
      OFS_HOST_SEQ, OFS_HOST_SVC, OFS_PRIO_A, OFS_PRIO_B, OFS_IRQ_FLAG,
      OFS_TIME_BASE_TWO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Partial writes to word-only registers are refused with an error
  always_comb begin
    pslverr = 1'b0;
    if (access && pwrite && mapped && paddr != OFS_IRQ_FLAG && !word_acc) begin
      pslverr = 1'b1;
    end
  end

  // Write enables per register
  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    return a == ofs;
  endfunction : hit

  // ==========================================================================
  // Module configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= RST_PRESCALE;
      counter2_gate_select <= 1'b0;
      stop_req <= 1'b0;
    end else if (wr && hit(paddr, OFS_MODULE_CONFIG)) begin
      prescale <= pwdata[MC_PRESCALE_LO +: 2];
      counter2_gate_select <= pwdata[MC_GATE_SEL];
      stop_req <= pwdata[MC_STOP];
    end
  end

  // Emulation bit locks after its first write; reset alone reopens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emulation_enable <= 1'b0;
      emu_locked <= 1'b0;
    end else if (wr && hit(paddr, OFS_MODULE_CONFIG) && !emu_locked) begin
      emulation_enable <= pwdata[MC_EMU];
      emu_locked <= 1'b1;
    end
  end

  // Stopped flag follows the engine's acknowledge of the stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopped_flag <= 1'b0;
    end else begin
      stopped_flag <= stop_req && stop_ack;
    end
  end

  // ==========================================================================
  // Interrupt level and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_level <= RST_IRQ_LEVEL;
      channel_irq_enable_reg <= '0;
    end else begin
      if (wr && hit(paddr, OFS_IRQ_CONFIG)) begin
        irq_request_level <= pwdata[IRQ_LEVEL_W-1:0];
      end
      if (wr && hit(paddr, OFS_IRQ_ENABLE)) begin
        channel_irq_enable_reg <= pwdata[NUM_CH-1:0];
      end
    end
  end

  // Flags: engine sets; a zero written after a read that saw the flag set clears.
  // A set in the same cycle as the clear wins, so no event is lost.
  logic [NUM_CH-1:0] flag_wr_data; // Lane-merged write data
  logic [NUM_CH-1:0] flag_clear; // Bits cleared this cycle
  assign flag_wr_data = merge16(channel_irq_flag_reg, pwdata, pstrb);
  assign flag_clear = (wr && hit(paddr, OFS_IRQ_FLAG)) ?
                      (flag_read_seen & ~flag_wr_data) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_flag_reg <= '0;
    end else begin
      channel_irq_flag_reg <= (channel_irq_flag_reg & ~flag_clear)
                              | engine_status.flag_set;
    end
  end

  // Remember which flags a read reported as set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_read_seen <= '0;
    end else if (rd && hit(paddr, OFS_IRQ_FLAG)) begin
      flag_read_seen <= channel_irq_flag_reg;
    end else begin
      flag_read_seen <= flag_read_seen & ~flag_clear;
    end
  end

  // Request needs flag, enable and a nonzero level together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq <= '0;
    end else begin
      channel_irq <= (irq_request_level != RST_IRQ_LEVEL) ?
                     (channel_irq_flag_reg & channel_irq_enable_reg) : '0;
    end
  end

  // ==========================================================================
  // Channel function, sequence and priority fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel <= '0;
      host_seq <= '0;
      channel_priority_reg_a <= '0;
      channel_priority_reg_b <= '0;
    end else if (wr) begin
      if (hit(paddr, OFS_FUNC_SEL_A)) func_sel[63:48] <= pwdata[15:0];
      if (hit(paddr, OFS_FUNC_SEL_B)) func_sel[47:32] <= pwdata[15:0];
      if (hit(paddr, OFS_HOST_SEQ)) host_seq <= pwdata;
      if (hit(paddr, OFS_PRIO_A)) channel_priority_reg_a <= pwdata[15:0];
      if (hit(paddr, OFS_PRIO_B)) channel_priority_reg_b <= pwdata[15:0];
    end
  end

  // Host service: host writes nonzero to request, engine returns the field to 00.
  // A host write in the same cycle as completion wins, keeping the new request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_svc <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr && hit(paddr, OFS_HOST_SVC)) begin
          host_svc[2*c +: 2] <= pwdata[2*c +: 2];
        end else if (engine_status.svc_done[c]) begin
          host_svc[2*c +: 2] <= HSR_IDLE;
        end
      end
    end
  end

  // Low half of the function fields has no register behind it and keeps its reset zero

  // ==========================================================================
  // Second time base: pin synchroniser, filter, sysclk_div_eight and prescaler
  logic [2:0] pin_sync; // Three flip-flop synchroniser
  logic pin_level; // Agreed pin level
  logic pin_prev; // Previous filtered level
  logic [2:0] filt_cnt; // Filter stability count
  logic pin_filtered; // Filtered pin level
  logic [2:0] sysclk_div_eight_cnt; // Sysclk divide by eight
  logic [2:0] pre_cnt; // Prescaler count
  logic base_tick; // Input edge to the prescaler
  logic pre_tick; // Prescaler output

  // Change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], counter2_external_pin};
      if (pin_sync[1] == pin_sync[2]) pin_level <= pin_sync[2];
    end
  end

  // Digital filter: level must stay put for several cycles before it is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt <= 3'h0;
      pin_filtered <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      if (pin_level == pin_filtered) begin
        filt_cnt <= 3'h0;
      end else if (filt_cnt == FILTER_LAST) begin
        pin_filtered <= pin_level;
        filt_cnt <= 3'h0;
      end else begin
        filt_cnt <= filt_cnt + 3'h1;
      end
      pin_prev <= pin_filtered;
    end
  end

  // Sysclk_div_eight runs only while not stopped, so the time base freezes with the engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_div_eight_cnt <= 3'h0;
    end else if (!stop_req) begin
      sysclk_div_eight_cnt <= sysclk_div_eight_cnt + 3'h1;
    end
  end

  // Source select: gated sysclk_div_eight or rising edge of filtered pin
  always_comb begin
    if (counter2_gate_select) begin
      base_tick = (sysclk_div_eight_cnt == SYSCLK_DIV_EIGHT_LAST) && pin_filtered;
    end else begin
      base_tick = pin_filtered && !pin_prev;
    end
  end

  // Prescaler divides ticks by 1,2,4 or 8
  assign pre_tick = base_tick && ((pre_cnt & ((3'h1 << prescale) - 3'h1)) ==
                                  ((3'h1 << prescale) - 3'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 3'h0;
    end else if (base_tick && !stop_req) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // Counter holds while stopped and resumes from its value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_two <= RST_TIME_BASE;
    end else if (pre_tick && !stop_req) begin
      time_base_two <= time_base_two + 16'h0001;
    end
  end

  // ==========================================================================
  // Engine control outputs
  assign ctrl.func_sel = func_sel;
  assign ctrl.host_seq = host_seq;
  assign ctrl.host_svc = host_svc;
  assign ctrl.prio = {channel_priority_reg_a, channel_priority_reg_b};
  assign ctrl.emulation_enable = emulation_enable;
  assign ctrl.engine_clk_en = !stop_req;
  assign emulation_ram_bus_block = emulation_enable;

  // ==========================================================================
  // Read mux; unmapped locations read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_MODULE_CONFIG: next_prdata = {26'h0, stopped_flag, stop_req, emulation_enable,
                                        counter2_gate_select, prescale};
      OFS_IRQ_CONFIG: next_prdata = {29'h0, irq_request_level};
      OFS_IRQ_ENABLE: next_prdata = {16'h0, channel_irq_enable_reg};
      OFS_FUNC_SEL_A: next_prdata = {16'h0, func_sel[63:48]};
      OFS_FUNC_SEL_B: next_prdata = {16'h0, func_sel[47:32]};
      OFS_HOST_SEQ: next_prdata = host_seq;
      OFS_HOST_SVC: next_prdata = host_svc;
      OFS_PRIO_A: next_prdata = {16'h0, channel_priority_reg_a};
      OFS_PRIO_B: next_prdata = {16'h0, channel_priority_reg_b};
      OFS_IRQ_FLAG: next_prdata = {16'h0, channel_irq_flag_reg};
      OFS_TIME_BASE_TWO: next_prdata = {time_base_one, time_base_two};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  assign prdata = rd ? next_prdata : 32'h0000_0000;

endmodule : tch_host_ctrl

// File: hw/tch_pkg.sv
// Package: register map, field layouts, reset values and shared types for the timer host control
package tch_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 9;

  // ==========================================================================
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [8:0] OFS_MODULE_CONFIG = 9'h000;
  localparam logic [8:0] OFS_IRQ_CONFIG = 9'h004;
  localparam logic [8:0] OFS_IRQ_ENABLE = 9'h008;
  localparam logic [8:0] OFS_FUNC_SEL_A = 9'h00C;
  localparam logic [8:0] OFS_FUNC_SEL_B = 9'h010;
  localparam logic [8:0] OFS_HOST_SEQ = 9'h014;
  localparam logic [8:0] OFS_HOST_SVC = 9'h018;
  localparam logic [8:0] OFS_PRIO_A = 9'h01C;
  localparam logic [8:0] OFS_PRIO_B = 9'h020;
  localparam logic [8:0] OFS_IRQ_FLAG = 9'h024;
  localparam logic [8:0] OFS_TIME_BASE_TWO = 9'h028;

  // ==========================================================================
  // Module configuration field positions
  localparam int MC_PRESCALE_LO = 0;
  localparam int MC_GATE_SEL = 2;
  localparam int MC_EMU = 3;
  localparam int MC_STOP = 4;
  localparam int MC_STOPPED = 5;
  localparam int IRQ_LEVEL_W = 3;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
  localparam logic [15:0] RST_TIME_BASE = 16'h0000;

  // ==========================================================================
  // Counts of cycles
  localparam logic [2:0] SYSCLK_DIV_EIGHT_LAST = 3'h7;
  localparam logic [2:0] FILTER_LAST = 3'h3;

  // ==========================================================================
  // Codes
  localparam logic [1:0] PRIO_DISABLED = 2'h0;
  localparam logic [1:0] HSR_IDLE = 2'h0;
  localparam logic [3:0] FN_SET_A_LOW = 4'h6;
  localparam logic [3:0] FN_SET_B_LOW = 4'h8;
  localparam logic [3:0] FN_PERIOD_PULSE_ACC = 4'hF;
  localparam logic [3:0] FN_OUTPUT_COMPARE = 4'hE;
  localparam logic [3:0] FN_STEPPER = 4'hD;

  // Control bundle handed to the microengine
  typedef struct packed {
    logic [NUM_CH*4-1:0] func_sel;
    logic [NUM_CH*2-1:0] host_seq;
    logic [NUM_CH*2-1:0] host_svc;
    logic [NUM_CH*2-1:0] prio;
    logic emulation_enable;
    logic engine_clk_en;
  } tch_ctrl_t;

  // Status bundle returned by the microengine
  typedef struct packed {
    logic [NUM_CH-1:0] flag_set;
    logic [NUM_CH-1:0] svc_done;
  } tch_engine_t;

endpackage : tch_pkg

// File: tb/tch_host_ctrl_assertions.sv
// Checker: concurrent properties on the host control ports
`timescale 1ns/1ps
module tch_host_ctrl_assertions
  import tch_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tch_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and engine side
  input wire logic counter2_external_pin,
  input wire logic stop_ack,
  input wire logic [15:0] time_base_one,
  input wire tch_pkg::tch_engine_t engine_status,
  input wire tch_pkg::tch_ctrl_t ctrl,
  input wire logic [15:0] time_base_two,
  input wire logic [tch_pkg::NUM_CH-1:0] channel_irq,
  input wire logic [tch_pkg::IRQ_LEVEL_W-1:0] irq_request_level,
  input wire logic emulation_ram_bus_block
);
  // ==========================================
  // Helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // APB access phase
  assign acc = psel && penable;
  // ==========================================
  // Properties
  AST_READY: assert property (acc |-> pready) else $error("pready low in access phase");
  AST_IDLE_RD: assert property (!acc |-> prdata == 32'h0) else $error("prdata not zero when idle");
  AST_UNMAPPED: assert property (acc && paddr >= 9'h040 |-> prdata == 32'h0 && !pslverr)
    else $error("unmapped access not quiet");
  AST_WORD_ONLY: assert property (acc && pwrite && paddr == OFS_IRQ_ENABLE && pstrb[1:0] != 2'h3
    |-> pslverr) else $error("byte write to word register accepted");
  AST_BYTE_OK: assert property (acc && paddr == OFS_IRQ_FLAG |-> !pslverr)
    else $error("byte access to flag register refused");
  AST_STOP_GATE: assert property (acc && pwrite && paddr == OFS_MODULE_CONFIG && pstrb[1:0] == 2'h3
    |=> ctrl.engine_clk_en == !$past(pwdata[MC_STOP])) else $error("engine clock enable wrong");
  AST_TB_HOLD: assert property (!ctrl.engine_clk_en && !$past(ctrl.engine_clk_en)
    |-> $stable(time_base_two)) else $error("counter moved while stopped");
  AST_TB_STEP: assert property ($changed(time_base_two) |-> time_base_two == $past(time_base_two) + 16'h1)
    else $error("counter step not one");
  AST_IRQ_LEVEL: assert property (irq_request_level == 3'h0 && $past(irq_request_level) == 3'h0
    |-> channel_irq == 16'h0) else $error("request with zero level");
  AST_EMU_BLOCK: assert property ($changed(emulation_ram_bus_block) |->
    $past(acc && pwrite && paddr == OFS_MODULE_CONFIG && !pslverr) &&
    emulation_ram_bus_block == ctrl.emulation_enable) else $error("bus block moved without a write");
  AST_EMU_ONCE: assert property ($past(ctrl.emulation_enable) |-> ctrl.emulation_enable)
    else $error("emulation bit cleared after being set");
  AST_SVC_DONE: assert property (engine_status.svc_done[0] && !(acc && pwrite && paddr == OFS_HOST_SVC)
    |=> ctrl.host_svc[1:0] == 2'h0) else $error("service field not returned to idle");
  AST_STOPPED: assert property (acc && !pwrite && paddr == OFS_MODULE_CONFIG && prdata[MC_STOPPED]
    |-> $past(!ctrl.engine_clk_en && stop_ack)) else $error("stopped flag without halt");
  // Main scenarios reached
  COV_IRQ: cover property (channel_irq != 16'h0);
  COV_HALT: cover property (stop_ack && !ctrl.engine_clk_en);
  COV_ERR: cover property (acc && pslverr);
endmodule : tch_host_ctrl_assertions

bind tch_host_ctrl tch_host_ctrl_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .counter2_external_pin(counter2_external_pin), .stop_ack(stop_ack),
  .time_base_one(time_base_one), .engine_status(engine_status), .ctrl(ctrl),
  .time_base_two(time_base_two), .channel_irq(channel_irq),
  .irq_request_level(irq_request_level), .emulation_ram_bus_block(emulation_ram_bus_block));

// File: tb/tch_engine_model.sv
// Partner: behavioural microengine facing the host control block
`timescale 1ns/1ps
module tch_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the block
  input wire tch_pkg::tch_ctrl_t ctrl,
  // Commands from the bench
  input wire logic [15:0] flag_req,
  input wire logic [15:0] done_req,
  // To the block
  output logic stop_ack,
  output logic [15:0] time_base_one,
  output tch_pkg::tch_engine_t engine_status
);
  import tch_pkg::*;
  // ==========================================
  // Halt handshake
  logic [1:0] halt_cnt; // Slow acknowledge, so the flag must wait for it
  // Acknowledge only after a few gated cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt <= 2'h0;
      stop_ack <= 1'b0;
    end else if (ctrl.engine_clk_en) begin
      halt_cnt <= 2'h0;
      stop_ack <= 1'b0;
    end else if (halt_cnt != 2'h3) begin
      halt_cnt <= halt_cnt + 2'h1;
    end else begin
      stop_ack <= 1'b1;
    end
  end
  // First time base runs only with clocks on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_one <= 16'h0000;
    end else if (ctrl.engine_clk_en) begin
      time_base_one <= time_base_one + 16'h0001;
    end
  end
  // Flags and service completion only on bench command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_status <= '0;
    end else begin
      engine_status.flag_set <= flag_req & {16{ctrl.engine_clk_en}};
      engine_status.svc_done <= done_req;
    end
  end
endmodule : tch_engine_model

// File: tb/tch_host_ctrl_tb.sv
// Testbench: APB sequences with expected values for the host control block
`timescale 1ns/1ps
module tch_host_ctrl_tb;
  import tch_pkg::*;
  // ==========================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, stop_ack, emu_blk;
  logic [15:0] tb1, tb2, irq, fl_req = 16'h0, dn_req = 16'h0, a;
  logic [2:0] lvl;
  tch_engine_t st;
  tch_ctrl_t ctrl;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  // ==========================================
  // Instances
  tch_host_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter2_external_pin(pin), .stop_ack(stop_ack),
    .time_base_one(tb1), .engine_status(st), .ctrl(ctrl), .time_base_two(tb2),
    .channel_irq(irq), .irq_request_level(lvl), .emulation_ram_bus_block(emu_blk));
  tch_engine_model i_eng (.pclk(pclk), .presetn(presetn), .ctrl(ctrl), .flag_req(fl_req),
    .done_req(dn_req), .stop_ack(stop_ack), .time_base_one(tb1), .engine_status(st));
  // ==========================================
  // Tasks
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; request held until pready is seen high at an edge, then one idle cycle
  // so the write has landed and psel is never dropped and raised in one time step
  task automatic apb(input logic w, input logic [8:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // Pulse engine commands for one cycle
  task automatic pulse(input logic [15:0] f, input logic [15:0] dn);
    fl_req <= f;
    dn_req <= dn;
    @(posedge pclk);
    fl_req <= 16'h0;
    dn_req <= 16'h0;
  endtask : pulse
  // Count increments of the second time base over n cycles
  task automatic rate(input int n, input int lo, input int hi);
    wt(20);
    a = tb2;
    wt(n);
    check(32'((tb2 - a) >= lo && (tb2 - a) <= hi), 32'h1);
  endtask : rate
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    wt(20);
    presetn <= 1'b1;
    wt(1);
    for (int o = 0; o <= 'h24; o += 4) begin
      apb(1'b0, 9'(o), 32'h0, 4'hF);
      check(rd, 32'h0);
    end
    apb(1'b1, 9'h100, 32'hFFFF, 4'hF);
    apb(1'b0, 9'h100, 32'h0, 4'hF);
    check({rd[30:0], er}, 32'h0);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h8, 4'hF);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h0, 4'hF);
    wt(1);
    check({ctrl.emulation_enable, emu_blk}, 32'h3);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0204, 4'hF);
    apb(1'b1, OFS_IRQ_ENABLE, 32'hFFFF, 4'h1);
    check(er, 1'b1);
    apb(1'b0, OFS_IRQ_ENABLE, 32'h0, 4'hF);
    check(rd, 32'h0204);
    apb(1'b1, OFS_FUNC_SEL_A, 32'hFEDC, 4'hF);
    apb(1'b1, OFS_FUNC_SEL_B, 32'h9876, 4'hF);
    check(ctrl.func_sel[63:32], 32'hFEDC9876);
    apb(1'b1, OFS_HOST_SEQ, 32'hA5A5, 4'hF);
    apb(1'b0, OFS_HOST_SEQ, 32'h0, 4'hF);
    check(rd, 32'hA5A5);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFS_PRIO_A, {16'h0, {8{2'(p)}}}, 4'hF);
      apb(1'b0, OFS_PRIO_A, 32'h0, 4'hF);
      check({rd[15:0], ctrl.prio[31:16]}, {2{{8{2'(p)}}}});
    end
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, OFS_HOST_SVC, 32'(c), 4'hF);
      apb(1'b0, OFS_HOST_SVC, 32'h0, 4'hF);
      check(rd, 32'(c));
      pulse(16'h0, 16'h0001);
      do apb(1'b0, OFS_HOST_SVC, 32'h0, 4'hF); while (rd !== 32'h0);
      check(ctrl.host_svc[1:0], 2'h0);
    end
    pulse(16'h0204, 16'h0);
    wt(3);
    check(irq, 16'h0);
    apb(1'b1, OFS_IRQ_CONFIG, 32'h3, 4'hF);
    wt(2);
    check(irq, 16'h0204);
    apb(1'b0, OFS_IRQ_CONFIG, 32'h0, 4'hF);
    check({rd[28:0], lvl}, 32'h1B);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0200, 4'hF);
    wt(2);
    check(irq, 16'h0200);
    apb(1'b1, OFS_IRQ_FLAG, 32'h0, 4'h1);
    check(er, 1'b0);
    apb(1'b0, OFS_IRQ_FLAG, 32'h0, 4'hF);
    check(rd, 32'h0204);
    apb(1'b1, OFS_IRQ_FLAG, 32'h0, 4'h1);
    apb(1'b0, OFS_IRQ_FLAG, 32'h0, 4'hF);
    check(rd, 32'h0200);
    apb(1'b1, OFS_IRQ_FLAG, 32'h0, 4'h2);
    apb(1'b0, OFS_IRQ_FLAG, 32'h0, 4'hF);
    wt(2);
    check({rd[15:0], irq}, 32'h0);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h4, 4'hF);
    pin <= 1'b1;
    rate(80, 9, 11);
    pin <= 1'b0;
    rate(80, 0, 0);
    pin <= 1'b1;
    apb(1'b1, OFS_MODULE_CONFIG, 32'h7, 4'hF);
    rate(640, 9, 11);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h1, 4'hF);
    wt(20);
    a = tb2;
    repeat (10) begin
      pin <= 1'b0;
      wt(10);
      pin <= 1'b1;
      wt(10);
    end
    wt(20);
    check(32'(tb2 - a), 32'h5);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h14, 4'hF);
    wt(10);
    a = tb2;
    apb(1'b0, OFS_MODULE_CONFIG, 32'h0, 4'hF);
    check(rd[MC_STOPPED], 1'b1);
    wt(100);
    check({tb2, ctrl.engine_clk_en}, {a, 1'b0});
    apb(1'b0, OFS_TIME_BASE_TWO, 32'h0, 4'hF);
    check(rd, {tb1, a});
    apb(1'b1, OFS_MODULE_CONFIG, 32'h4, 4'hF);
    wt(2);
    apb(1'b0, OFS_MODULE_CONFIG, 32'h0, 4'hF);
    check(rd[MC_STOPPED], 1'b0);
    rate(80, 9, 11);
    // Mid-run reset must reopen the emulation bit for one more write
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(1);
    check({ctrl.emulation_enable, emu_blk}, 32'h0);
    apb(1'b1, OFS_MODULE_CONFIG, 32'h8, 4'hF);
    check({ctrl.emulation_enable, emu_blk}, 32'h3);
    end_sim();
  end
endmodule : tch_host_ctrl_tb
